// [logic/acsi_status_irq.sv]
// Global status and interrupt section of the audio link controller
// What this block does
// - Bit 0 sticky frame start since last read
// - Bit 1 sticky wake on data rising edge
// - Bit 2 high while codec status AND mask
// - Bit 3 high while channel A status AND mask
// - Bit 4 high while channel B status AND mask
// - Enable-set write sets masks of one bits
// - Enable-clear write clears masks of one bits
// - Mask read returns enabled sources, status layout
// - Status read clears wake and frame flags
//
// The address map and strobed register access are this design's own decisions.
`include "acsi_consts.svh"

module acsi_status_irq
(
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic [`ACSI_ADDR_W-1:0] addr_in,
   input wire logic [`ACSI_DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [`ACSI_DATA_W-1:0] rd_data_out,
   input wire acsi_pkg::acsi_chan_s codec_chan_in,
   input wire acsi_pkg::acsi_chan_s chan_a_in,
   input wire acsi_pkg::acsi_chan_s chan_b_in,
   input wire logic bit_clk_in,
   input wire logic frame_sync_in,
   input wire logic sdata_in,
   output logic irq_out
);

   acsi_pkg::acsi_req_s req;
   acsi_pkg::acsi_chan_s chans [`ACSI_NUM_CHAN];
   logic [`ACSI_NUM_CHAN-1:0] chan_event;
   logic [1:0] clk_sync;
   logic [1:0] sync_sync;
   logic [1:0] data_sync;
   logic clk_prev;
   logic sync_prev;
   logic data_prev;
   logic sof_flag;
   logic codec_wake_flag;
   acsi_pkg::acsi_src_t mask;
   acsi_pkg::acsi_src_t status;
   acsi_pkg::acsi_src_t next_mask;
   wire clk_rise;
   wire frame_start;
   wire wake_edge;
   wire sel_status;
   wire sel_en_set;
   wire sel_en_clr;
   wire sel_mask;
   wire status_read;
   wire [`ACSI_DATA_W-1:0] next_rd_data;

   assign req = '{addr: addr_in, wdata: wr_data_in, wr: wr_in, rd: rd_in};
   assign chans[`ACSI_CHAN_IDX_CODEC] = codec_chan_in;
   assign chans[`ACSI_CHAN_IDX_A] = chan_a_in;
   assign chans[`ACSI_CHAN_IDX_B] = chan_b_in;

   // Channel events follow their condition with no memory
   genvar gi;
   generate
      for (gi = 0; gi < `ACSI_NUM_CHAN; gi = gi + 1)
      begin : g_chan
         assign chan_event[gi] = |(chans[gi].status & chans[gi].mask);
      end
   endgenerate

   // Two-stage synchronisers on the link pins
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         clk_sync <= `ACSI_SYNC_RESET;
         sync_sync <= `ACSI_SYNC_RESET;
         data_sync <= `ACSI_SYNC_RESET;
      end
      else
      begin
         clk_sync <= {clk_sync[0], bit_clk_in};
         sync_sync <= {sync_sync[0], frame_sync_in};
         data_sync <= {data_sync[0], sdata_in};
      end
   end

   // Edge history on synchronised levels
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         clk_prev <= `ACSI_FLAG_RESET;
         sync_prev <= `ACSI_FLAG_RESET;
         data_prev <= `ACSI_FLAG_RESET;
      end
      else
      begin
         clk_prev <= clk_sync[1];
         data_prev <= data_sync[1];
         if (clk_rise)
         begin
            sync_prev <= sync_sync[1];
         end
      end
   end

   // Frame start: sync sampled high on a bit clock rise after low
   assign clk_rise = clk_sync[1] & ~clk_prev;
   assign frame_start = clk_rise & sync_sync[1] & ~sync_prev;
   // Wake: data rising edge, independent of the bit clock
   assign wake_edge = data_sync[1] & ~data_prev;

   // Register decode
   assign sel_status = req.addr == `ACSI_OFF_STATUS;
   assign sel_en_set = req.addr == `ACSI_OFF_EN_SET;
   assign sel_en_clr = req.addr == `ACSI_OFF_EN_CLR;
   assign sel_mask = req.addr == `ACSI_OFF_MASK;
   assign status_read = req.rd & sel_status;

   assign status[`ACSI_BIT_SOF] = sof_flag;
   assign status[`ACSI_BIT_WAKE] = codec_wake_flag;
   assign status[`ACSI_BIT_CODEC] = chan_event[`ACSI_CHAN_IDX_CODEC];
   assign status[`ACSI_BIT_CHAN_A] = chan_event[`ACSI_CHAN_IDX_A];
   assign status[`ACSI_BIT_CHAN_B] = chan_event[`ACSI_CHAN_IDX_B];

   // Set and clear ports act on one-bits only
   assign next_mask = (req.wr & sel_en_clr) ? (mask & ~req.wdata[`ACSI_NUM_SRC-1:0]) :
                      (req.wr & sel_en_set) ? (mask | req.wdata[`ACSI_NUM_SRC-1:0]) :
                      mask;

   // Read mux, unmapped and write-only offsets read zero
   assign next_rd_data = !req.rd ? `ACSI_DATA_ZERO :
                         sel_status ? {{(`ACSI_DATA_W-`ACSI_NUM_SRC){1'b0}}, status} :
                         sel_mask ? {{(`ACSI_DATA_W-`ACSI_NUM_SRC){1'b0}}, mask} :
                         `ACSI_DATA_ZERO;

   // Sticky flags: a new event beats the read clear
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         sof_flag <= `ACSI_FLAG_RESET;
         codec_wake_flag <= `ACSI_FLAG_RESET;
      end
      else
      begin
         sof_flag <= frame_start | (sof_flag & ~status_read);
         codec_wake_flag <= wake_edge | (codec_wake_flag & ~status_read);
      end
   end

   // Mask, read data and interrupt line
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         mask <= `ACSI_MASK_RESET;
         rd_data_out <= `ACSI_DATA_ZERO;
         irq_out <= `ACSI_FLAG_RESET;
      end
      else
      begin
         mask <= next_mask;
         rd_data_out <= next_rd_data;
         irq_out <= |(status & mask);
      end
   end

endmodule

// [shared/acsi_consts.svh]
// Offsets, field positions, widths and reset values of the status and interrupt block
`ifndef ACSI_CONSTS_SVH
`define ACSI_CONSTS_SVH

`define ACSI_ADDR_W 8
`define ACSI_DATA_W 32
`define ACSI_NUM_SRC 5
`define ACSI_CHAN_W 16
`define ACSI_NUM_CHAN 3

`define ACSI_OFF_STATUS 8'h00
`define ACSI_OFF_EN_SET 8'h04
`define ACSI_OFF_EN_CLR 8'h08
`define ACSI_OFF_MASK 8'h0c

`define ACSI_BIT_SOF 0
`define ACSI_BIT_WAKE 1
`define ACSI_BIT_CODEC 2
`define ACSI_BIT_CHAN_A 3
`define ACSI_BIT_CHAN_B 4

`define ACSI_CHAN_IDX_CODEC 0
`define ACSI_CHAN_IDX_A 1
`define ACSI_CHAN_IDX_B 2

`define ACSI_MASK_RESET 5'h00
`define ACSI_FLAG_RESET 1'h0
`define ACSI_DATA_ZERO 32'h0000_0000
`define ACSI_CHAN_ZERO 16'h0000
`define ACSI_SYNC_RESET 2'h0

`endif

// [shared/acsi_pkg.sv]
// Types shared by the status and interrupt block
`include "acsi_consts.svh"

package acsi_pkg;

   typedef logic [`ACSI_NUM_SRC-1:0] acsi_src_t;

   // Status and mask of one channel, supplied by the channel logic
   typedef struct packed
   {
      logic [`ACSI_CHAN_W-1:0] status;
      logic [`ACSI_CHAN_W-1:0] mask;
   } acsi_chan_s;

   // Register bus request
   typedef struct packed
   {
      logic [`ACSI_ADDR_W-1:0] addr;
      logic [`ACSI_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } acsi_req_s;

endpackage

// [tb/acsi_codec_model.sv]
// Codec model on the link pins
module acsi_codec_model
(
   output logic bclk_out = 1'b0,
   output logic sync_out = 1'b0,
   output logic sd_out = 1'b0
);
   timeunit 1ns / 1ns;
   task automatic frame();
      #3;
      for (int i = 0; i < 4; i++)
      begin
         #40 bclk_out = 1'b1;
         #2 sync_out = i < 2;
         #38 bclk_out = 1'b0;
      end
      sync_out = 1'b0;
   endtask
   task automatic wake();
      #40 sd_out = 1'b1;
      #80 sd_out = 1'b0;
   endtask
endmodule

// [tb/acsi_status_irq_chk.sv]
// Checker of the status and interrupt block
module acsi_status_irq_chk
(
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rd_data_out,
   input wire acsi_pkg::acsi_chan_s codec_chan_in,
   input wire acsi_pkg::acsi_chan_s chan_a_in,
   input wire acsi_pkg::acsi_chan_s chan_b_in,
   input wire logic irq_out
);
   timeunit 1ns / 1ns;
   logic [4:0] m;
   wire [2:0] ev = {|(chan_b_in.status & chan_b_in.mask), |(chan_a_in.status & chan_a_in.mask),
      |(codec_chan_in.status & codec_chan_in.mask)};
   wire sr = rd_in && addr_in == 8'h00;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   always_ff @(posedge clock_in)
      m <= !rst_b_in ? 5'h00 : !wr_in ? m : addr_in == 8'h04 ? m | wr_data_in[4:0] :
         addr_in == 8'h08 ? m & ~wr_data_in[4:0] : m;
   rd_idle_a: assert property (!$past(rd_in) |-> !rd_data_out) else $error("idle");
   rd_upper_a: assert property (rd_data_out[31:5] == 0) else $error("upper");
   chan_evt_a: assert property ($past(sr) |-> rd_data_out[4:2] == $past(ev)) else $error("chan");
   wo_read_a: assert property ($past(rd_in && addr_in == 8'h08) |-> !rd_data_out) else $error("wo");
   mask_read_a: assert property ($past(rd_in && addr_in == 8'h0c) |-> rd_data_out[4:0] == $past(m))
      else $error("mask");
   irq_chan_a: assert property (|$past(m[4:2] & ev) |-> irq_out) else $error("irq");
   irq_only_a: assert property (irq_out && !$past(m[1:0]) |-> |$past(m[4:2] & ev)) else $error("only");
   irq_off_a: assert property (!$past(m) |-> !irq_out) else $error("off");
endmodule
bind acsi_status_irq acsi_status_irq_chk u_chk(.*);

// [tb/tb_acsi_status_irq.sv]
// Bench of the status and interrupt block
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
   $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_acsi_status_irq;
   timeunit 1ns / 1ns;
   logic clock_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, irq_out, bit_clk_in, frame_sync_in, sdata_in;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wr_data_in = 32'h0, rd_data_out;
   acsi_pkg::acsi_chan_s codec_chan_in = 32'h0, chan_a_in = 32'h0, chan_b_in = 32'h0;
   int fails = 0, num_checks = 0;
   acsi_codec_model u_codec(.bclk_out(bit_clk_in), .sync_out(frame_sync_in), .sd_out(sdata_in));
   acsi_status_irq u_dut(.*);
   initial forever #4 clock_in = ~clock_in;
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in);
      {wr_in, rd_in, addr_in, wr_data_in} <= {w, !w, a, v};
      @(posedge clock_in);
      {wr_in, rd_in} <= 2'h0;
      @(negedge clock_in);
      if (!w)
         `CHK(rd_data_out, v)
   endtask
   task automatic t_mask();
      bus(0, 8'h0c, 32'h0);
      bus(1, 8'h04, 32'h15);
      bus(0, 8'h0c, 32'h15);
      bus(1, 8'h08, 32'hffff_fff9);
      bus(0, 8'h0c, 32'h04);
      bus(0, 8'h08, 32'h0);
   endtask
   task automatic t_chan();
      @(posedge clock_in);
      {codec_chan_in, chan_a_in, chan_b_in} <= 96'h0003_0002_00f0_000f_8000_8000;
      bus(0, 8'h00, 32'h14);
      `CHK(irq_out, 1'b1)
      bus(1, 8'h08, 32'h04);
      @(negedge clock_in);
      `CHK(irq_out, 1'b0)
   endtask
   task automatic t_link();
      bus(1, 8'h04, 32'h03);
      u_codec.frame();
      repeat (5) @(negedge clock_in);
      `CHK(irq_out, 1'b1)
      bus(0, 8'h00, 32'h15);
      bus(0, 8'h00, 32'h14);
      u_codec.wake();
      bus(0, 8'h00, 32'h16);
      bus(0, 8'h00, 32'h14);
   endtask
   task automatic final_report();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #20us;
      fails++;
      final_report();
   end
   initial
   begin
      repeat (6) @(posedge clock_in);
      rst_b_in <= 1'b1;
      t_mask();
      t_chan();
      t_link();
      final_report();
   end
endmodule
